// >>> pot_pkg.sv
// package for the programmable output terminals: register map, codes, timing
// assumes a parameter bus that writes whole 16-bit words by index
package pot_pkg;

  // ************************************************************
  // register indices (no offsets printed; our own numbering)
  // ************************************************************
  localparam logic [3:0] REG_OC_SEL = 4'h0;
  localparam logic [3:0] REG_R1_SEL = 4'h1;
  localparam logic [3:0] REG_R2_SEL = 4'h2;
  localparam logic [3:0] REG_POL = 4'h3;
  localparam logic [3:0] REG_OC_ON = 4'h4;
  localparam logic [3:0] REG_OC_OFF = 4'h5;
  localparam logic [3:0] REG_R1_ON = 4'h6;
  localparam logic [3:0] REG_R1_OFF = 4'h7;
  localparam logic [3:0] REG_R2_ON = 4'h8;
  localparam logic [3:0] REG_R2_OFF = 4'h9;
  localparam logic [3:0] REG_FREQ_THR = 4'hA;
  localparam logic [3:0] REG_FREQ_QT = 4'hB;
  localparam logic [3:0] REG_FAULT_SNAP = 4'hC;
  localparam logic [3:0] REG_STATE = 4'hD;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] RST_OC_SEL = 16'h0000;
  localparam logic [15:0] RST_R1_SEL = 16'h0001;
  localparam logic [15:0] RST_R2_SEL = 16'h0005;
  localparam logic [15:0] RST_POL = 16'h0000;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  // 1.00 Hz in 0.01 Hz units
  localparam logic [15:0] RST_FREQ_THR = 16'h0064;
  // 0.5 s in 0.1 s units
  localparam logic [15:0] RST_FREQ_QT = 16'h0005;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POL_BIT_OC = 0;
  localparam int POL_BIT_R1 = 2;
  localparam int POL_BIT_R2 = 3;
  localparam int SEL_W = 6;
  localparam logic [15:0] POL_MASK = 16'h000F;
  localparam logic [15:0] DELAY_MAX = 16'hC350;

  // ************************************************************
  // function selection codes
  // ************************************************************
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_FAULT = 6'h05;
  localparam logic [5:0] FN_RUN_TIME = 6'h16;
  localparam logic [5:0] FN_MODBUS = 6'h17;
  localparam logic [5:0] FN_DC_BUS = 6'h1A;
  localparam logic [5:0] FN_STO = 6'h1D;
  localparam logic [5:0] FN_ANY_FREQ = 6'h25;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int QT_UNIT_MS = 100;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic run_time_reached;
    logic modbus_bit;
    logic dc_bus_ok;
    logic sto_fault;
    logic drive_fault;
    logic running;
  } pot_src_s;

  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [15:0] wdata;
  } pot_wr_s;

endpackage

// >>> pot_delay.sv
// one terminal's on/off delay timer working in millisecond ticks
// assumes a one-cycle tick pulse and delay settings in milliseconds
`timescale 1ns/100ps
module pot_delay (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_level,
  input wire logic [15:0] i_on_ms,
  input wire logic [15:0] i_off_ms,
  output logic o_level
);
  import pot_pkg::*;

  logic [15:0] count;
  logic [15:0] target;

  assign target = i_level ? i_on_ms : i_off_ms;

  // restart whenever source equals output again; count only while differ
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      count <= 16'h0000;
    end else if (i_ce) begin
      if (i_level == o_level) begin
        count <= 16'h0000;
      end else if (i_tick && count < target) begin
        count <= count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else if (i_ce) begin
      if (i_level != o_level && count >= target) begin
        o_level <= i_level;
      end
    end
  end

  a_zero_delay_follow: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && i_level && !o_level && i_on_ms == 16'h0000)
    |=> o_level)
    else $error("zero on delay did not pass level");

  // a pending rise with the count short of its setting must not switch
  a_hold_until_due: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (!o_level && i_level && count < target) |=> !o_level)
    else $error("output rose before on delay elapsed");

endmodule

// >>> pot_outputs.sv
// programmable digital output terminals: open collector and two relays
// assumes source conditions synchronous to i_sys_clk and a simple
// word-indexed parameter port (write strobe, index, data; read data)
`timescale 1ns/100ps
module pot_outputs #(
  parameter int TICK_DIV = pot_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire pot_pkg::pot_src_s i_src,
  input wire logic [15:0] i_ramp_freq,
  input wire pot_pkg::pot_wr_s i_wr,
  input wire logic [3:0] i_rd_idx,
  output logic [15:0] o_rd_data,
  output logic o_open_collector_out,
  output logic o_relay_out_one,
  output logic o_relay_out_two
);
  import pot_pkg::*;

  // ************************************************************
  // parameter registers
  // ************************************************************
  logic [5:0] sel [3];
  logic [15:0] polarity;
  logic [15:0] on_ms [3];
  logic [15:0] off_ms [3];
  logic [15:0] freq_thr;
  logic [15:0] freq_qt;
  logic [15:0] fault_snap;
  logic [2:0] term_out;
  logic [2:0] next_term_out;

  function automatic logic [15:0] clamp_delay(input logic [15:0] v);
    clamp_delay = (v > DELAY_MAX) ? DELAY_MAX : v;
  endfunction

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sel[0] <= RST_OC_SEL[SEL_W-1:0];
      sel[1] <= RST_R1_SEL[SEL_W-1:0];
      sel[2] <= RST_R2_SEL[SEL_W-1:0];
    end else if (i_ce && i_wr.wr) begin
      // values above 63 keep only the six code bits
      case (i_wr.idx)
        REG_OC_SEL: sel[0] <= i_wr.wdata[SEL_W-1:0];
        REG_R1_SEL: sel[1] <= i_wr.wdata[SEL_W-1:0];
        REG_R2_SEL: sel[2] <= i_wr.wdata[SEL_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      polarity <= RST_POL;
    end else if (i_ce && i_wr.wr && i_wr.idx == REG_POL) begin
      polarity <= i_wr.wdata & POL_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 3; k++) begin
        on_ms[k] <= RST_DELAY;
        off_ms[k] <= RST_DELAY;
      end
    end else if (i_ce && i_wr.wr) begin
      // delays held in ms, capped at 50.000 s
      case (i_wr.idx)
        REG_OC_ON: on_ms[0] <= clamp_delay(i_wr.wdata);
        REG_OC_OFF: off_ms[0] <= clamp_delay(i_wr.wdata);
        REG_R1_ON: on_ms[1] <= clamp_delay(i_wr.wdata);
        REG_R1_OFF: off_ms[1] <= clamp_delay(i_wr.wdata);
        REG_R2_ON: on_ms[2] <= clamp_delay(i_wr.wdata);
        REG_R2_OFF: off_ms[2] <= clamp_delay(i_wr.wdata);
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      freq_thr <= RST_FREQ_THR;
      freq_qt <= RST_FREQ_QT;
    end else if (i_ce && i_wr.wr) begin
      case (i_wr.idx)
        REG_FREQ_THR: freq_thr <= i_wr.wdata;
        REG_FREQ_QT: freq_qt <= i_wr.wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // millisecond tick
  // ************************************************************
  logic [17:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 18'(TICK_DIV - 1));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt <= 18'h00000;
    end else if (i_ce) begin
      tick_cnt <= tick ? 18'h00000 : tick_cnt + 18'h00001;
    end
  end

  // ************************************************************
  // any-frequency-reached qualification
  // ************************************************************
  logic freq_above;
  // wide enough for the full 16-bit qualify setting times 100 ms
  logic [22:0] qual_ms;
  logic [22:0] qual_target;
  logic any_freq;

  assign freq_above = i_ramp_freq > freq_thr;
  assign qual_target = 23'(freq_qt) * 23'(QT_UNIT_MS);

  // drop of the condition clears at once; only rising is qualified
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      qual_ms <= 23'h000000;
    end else if (i_ce) begin
      if (!freq_above) begin
        qual_ms <= 23'h000000;
      end else if (tick && qual_ms < qual_target) begin
        qual_ms <= qual_ms + 23'h000001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      any_freq <= 1'b0;
    end else if (i_ce) begin
      any_freq <= freq_above && qual_ms >= qual_target;
    end
  end

  // ************************************************************
  // per terminal: source select, delay, polarity
  // ************************************************************
  logic [2:0] raw;
  logic [2:0] delayed;
  logic [2:0] pol_bits;

  assign pol_bits = {polarity[POL_BIT_R2], polarity[POL_BIT_R1],
                     polarity[POL_BIT_OC]};

  // each terminal decodes its own code from shared sources
  for (genvar t = 0; t < 3; t++) begin : g_term
    always_comb begin
      case (sel[t])
        FN_NONE: raw[t] = 1'b0;
        FN_FAULT: raw[t] = i_src.drive_fault;
        6'h01: raw[t] = i_src.running;
        FN_RUN_TIME: raw[t] = i_src.run_time_reached;
        FN_MODBUS: raw[t] = i_src.modbus_bit;
        FN_DC_BUS: raw[t] = i_src.dc_bus_ok;
        FN_STO: raw[t] = i_src.sto_fault;
        FN_ANY_FREQ: raw[t] = any_freq;
        default: raw[t] = 1'b0;
      endcase
    end

    pot_delay u_delay (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_tick(tick),
      .i_level(raw[t]),
      .i_on_ms(on_ms[t]),
      .i_off_ms(off_ms[t]),
      .o_level(delayed[t])
    );
  end

  assign next_term_out = delayed ^ pol_bits;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      term_out <= 3'h0;
    end else if (i_ce) begin
      term_out <= next_term_out;
    end
  end

  assign o_open_collector_out = term_out[0];
  assign o_relay_out_one = term_out[1];
  assign o_relay_out_two = term_out[2];

  // snapshot of outputs taken on the rising edge of drive fault
  logic fault_d;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_d <= 1'b0;
      fault_snap <= 16'h0000;
    end else if (i_ce) begin
      fault_d <= i_src.drive_fault;
      if (i_src.drive_fault && !fault_d) begin
        fault_snap <= {13'h0000, term_out};
      end
    end
  end

  // ************************************************************
  // readback
  // ************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 16'h0000;
    end else if (i_ce) begin
      case (i_rd_idx)
        REG_OC_SEL: o_rd_data <= {10'h000, sel[0]};
        REG_R1_SEL: o_rd_data <= {10'h000, sel[1]};
        REG_R2_SEL: o_rd_data <= {10'h000, sel[2]};
        REG_POL: o_rd_data <= polarity;
        REG_OC_ON: o_rd_data <= on_ms[0];
        REG_OC_OFF: o_rd_data <= off_ms[0];
        REG_R1_ON: o_rd_data <= on_ms[1];
        REG_R1_OFF: o_rd_data <= off_ms[1];
        REG_R2_ON: o_rd_data <= on_ms[2];
        REG_R2_OFF: o_rd_data <= off_ms[2];
        REG_FREQ_THR: o_rd_data <= freq_thr;
        REG_FREQ_QT: o_rd_data <= freq_qt;
        REG_FAULT_SNAP: o_rd_data <= fault_snap;
        REG_STATE: o_rd_data <= {13'h0000, term_out};
        default: o_rd_data <= 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_state_read;
    i_ce && i_rd_idx == REG_STATE;
  endsequence

  a_state_readback: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    s_state_read |=> o_rd_data == {13'h0000, $past(term_out)})
    else $error("state readback mismatch");

  a_code_zero_off: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    sel[0] == FN_NONE |-> !raw[0])
    else $error("code 0 terminal active");

  // the open collector walks through every FN_ code in the bench; code 6'h01 is never selected on it, only relay one resets to it
  a_code_select: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (sel[0] == FN_STO |-> raw[0] == i_src.sto_fault) and
    (sel[0] == FN_DC_BUS |-> raw[0] == i_src.dc_bus_ok) and
    (sel[0] == FN_MODBUS |-> raw[0] == i_src.modbus_bit) and
    (sel[0] == FN_RUN_TIME |-> raw[0] == i_src.run_time_reached) and
    (sel[2] == FN_FAULT |-> raw[2] == i_src.drive_fault))
    else $error("selected source not routed");

  // checked per pin against the register bits, not the packed copy
  a_polarity_apply: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    i_ce |=> term_out[0] == $past(delayed[0] ^ polarity[POL_BIT_OC]) &&
      term_out[1] == $past(delayed[1] ^ polarity[POL_BIT_R1]) &&
      term_out[2] == $past(delayed[2] ^ polarity[POL_BIT_R2]))
    else $error("polarity not applied to delayed level");

  a_freq_needs_qual: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    $rose(any_freq) |-> $past(qual_ms) >= $past(qual_target))
    else $error("frequency reached without qualification");

  a_freq_drop: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (i_ce && !freq_above) |=> !any_freq)
    else $error("frequency reached held after drop");

  a_tick_period: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (tick && i_ce) |=> !tick)
    else $error("tick repeated on consecutive cycles");

  a_reset_codes: assert property (@(posedge i_sys_clk)
    $rose(i_rst_n) |-> sel[0] == 6'h00 && sel[1] == 6'h01 &&
      sel[2] == 6'h05)
    else $error("selection reset defaults wrong");

endmodule

// >>> pot_load.sv
// load model: relay coils and plc inputs hung on the output pins
// assumes pins are registered levels on the system clock
`timescale 1ns/100ps
module pot_load (
  input wire logic i_sys_clk,
  input wire logic i_oc,
  input wire logic i_r1,
  input wire logic i_r2,
  output logic [2:0] o_seen
);
  // ************************************************************
  // coil state as the load samples it
  // ************************************************************
  // one flop of lag, like an input filter on the far side
  always_ff @(posedge i_sys_clk) begin
    o_seen <= {i_r2, i_r1, i_oc};
  end
endmodule

// >>> programmable_output_terminals_tb.sv
// testbench for the programmable output terminals
// assumes a 10-cycle tick so one millisecond is 10 clocks
`timescale 1ns/100ps
module programmable_output_terminals_tb;
  import pot_pkg::*;
  localparam int DIV = 10;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ce = 1'b1;
  pot_src_s src = '0;
  logic [15:0] freq = 16'h0000;
  pot_wr_s wbus = '0;
  logic [3:0] rd_idx = 4'h0;
  logic [15:0] rd_data;
  logic oc;
  logic r1;
  logic r2;
  logic [2:0] seen;
  int error_cnt = 0;
  int n_tests = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  pot_outputs #(.TICK_DIV(DIV)) i_dut (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(ce),
    .i_src(src),
    .i_ramp_freq(freq),
    .i_wr(wbus),
    .i_rd_idx(rd_idx),
    .o_rd_data(rd_data),
    .o_open_collector_out(oc),
    .o_relay_out_one(r1),
    .o_relay_out_two(r2)
  );

  pot_load i_load (
    .i_sys_clk(i_sys_clk),
    .i_oc(oc),
    .i_r1(r1),
    .i_r2(r2),
    .o_seen(seen)
  );

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] idx, input logic [15:0] d);
    @(negedge i_sys_clk);
    wbus.wr = 1'b1;
    wbus.idx = idx;
    wbus.wdata = d;
    @(negedge i_sys_clk);
    wbus.wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] idx, input logic [15:0] exp);
    @(negedge i_sys_clk);
    rd_idx = idx;
    repeat (2) @(negedge i_sys_clk);
    chk(rd_data, exp);
  endtask

  // pins through the load, which adds a cycle
  task automatic pins(input logic [2:0] exp);
    repeat (4) @(negedge i_sys_clk);
    chk({13'h0000, seen}, {13'h0000, exp});
  endtask

  task automatic wait_oc(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (oc !== v && n < hi) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (oc !== v) begin
      error_cnt++;
      $display("[FAIL] %0t open collector stuck", $time);
      end_of_test;
    end else begin
      chk(16'(n >= lo), 16'h0001);
    end
  endtask

  task automatic code_case(input logic [5:0] code, input int b);
    wr_reg(REG_OC_SEL, {10'h000, code});
    src = '0;
    pins(3'b000);
    src = pot_src_s'(6'h01 << b);
    repeat (4) @(negedge i_sys_clk);
    chk({15'h0000, seen[0]}, 16'h0001);
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    rd_reg(REG_OC_SEL, 16'h0000);
    rd_reg(REG_R1_SEL, 16'h0001);
    rd_reg(REG_R2_SEL, 16'h0005);
    rd_reg(REG_POL, 16'h0000);
    rd_reg(REG_FREQ_THR, 16'h0064);
    rd_reg(REG_FREQ_QT, 16'h0005);
    rd_reg(REG_STATE, 16'h0000);
    wr_reg(REG_OC_SEL, 16'h003F);
    rd_reg(REG_OC_SEL, 16'h003F);
    wr_reg(REG_OC_ON, 16'hFFFF);
    rd_reg(REG_OC_ON, 16'hC350);
    wr_reg(REG_OC_ON, 16'h0000);
    rd_reg(4'hE, 16'h0000);
    $display("test registers done");

    code_case(FN_RUN_TIME, 5);
    code_case(FN_MODBUS, 4);
    code_case(FN_DC_BUS, 3);
    code_case(FN_STO, 2);
    code_case(FN_FAULT, 1);
    wr_reg(REG_OC_SEL, {10'h000, FN_NONE});
    src = 6'h3F;
    repeat (4) @(negedge i_sys_clk);
    chk({15'h0000, seen[0]}, 16'h0000);
    $display("test codes done");

    src = '0;
    src.modbus_bit = 1'b1;
    wr_reg(REG_OC_SEL, {10'h000, FN_MODBUS});
    wr_reg(REG_R1_SEL, {10'h000, FN_MODBUS});
    wr_reg(REG_R2_SEL, {10'h000, FN_MODBUS});
    pins(3'b111);
    rd_reg(REG_STATE, 16'h0007);
    src.drive_fault = 1'b1;
    rd_reg(REG_FAULT_SNAP, 16'h0007);
    src.drive_fault = 1'b0;
    src.modbus_bit = 1'b0;
    wr_reg(REG_POL, 16'h000D);
    pins(3'b111);
    wr_reg(REG_POL, 16'h0004);
    pins(3'b010);
    rd_reg(REG_STATE, 16'h0002);
    wr_reg(REG_POL, 16'h0002);
    pins(3'b000);
    // clock enable low must freeze pins although the source rises
    ce = 1'b0;
    src.modbus_bit = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk({13'h0000, r2, r1, oc}, 16'h0000);
    ce = 1'b1;
    src.modbus_bit = 1'b0;
    $display("test polarity done");

    // 3 ms on, 2 ms off; first tick may land early
    wr_reg(REG_OC_ON, 16'h0003);
    wr_reg(REG_OC_OFF, 16'h0002);
    src.modbus_bit = 1'b1;
    wait_oc(1'b1, 15, 45);
    src.modbus_bit = 1'b0;
    wait_oc(1'b0, 8, 35);
    // short blip must be swallowed by the restarting counter
    src.modbus_bit = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    src.modbus_bit = 1'b0;
    repeat (40) @(negedge i_sys_clk);
    chk({15'h0000, oc}, 16'h0000);
    wr_reg(REG_POL, 16'h0001);
    // inverted pin needs a cycle to show before the source rises
    repeat (2) @(negedge i_sys_clk);
    chk({15'h0000, oc}, 16'h0001);
    src.modbus_bit = 1'b1;
    wait_oc(1'b0, 15, 45);
    src.modbus_bit = 1'b0;
    wr_reg(REG_POL, 16'h0000);
    wr_reg(REG_OC_ON, 16'h0000);
    wr_reg(REG_OC_OFF, 16'h0000);
    $display("test delays done");

    // 0.1 s qualification is 100 ticks of 10 clocks
    wr_reg(REG_FREQ_QT, 16'h0001);
    wr_reg(REG_OC_SEL, {10'h000, FN_ANY_FREQ});
    freq = 16'h0065;
    wait_oc(1'b1, 950, 1100);
    freq = 16'h0064;
    wait_oc(1'b0, 0, 4);
    $display("test frequency done");
    end_of_test;
  end
endmodule
